/* rtl/brp_pkg.sv */
package brp_pkg;

  // Configuration dword offsets
  localparam logic [7:0] OFS_CAP_PTR = 8'h34;
  localparam logic [7:0] OFS_BRIDGE_CONTROL = 8'h3C;
  localparam logic [7:0] OFS_DIAG_CHIP_CONTROL = 8'h40;
  localparam logic [7:0] OFS_SEC_CLOCK_CONTROL = 8'h68;
  localparam logic [7:0] OFS_PM_CAP = 8'hDC;
  localparam logic [7:0] OFS_PM_DATA = 8'hE0;

  // Field positions
  localparam int BC_SEC_RESET_BIT = 6;
  localparam int DIAG_CHIP_RESET_BIT = 1;
  localparam int PPB_CLK_STOP_BIT = 7;
  localparam int PPB_B2_B3_BIT = 6;

  // Reset and fixed values
  localparam logic [15:0] BRIDGE_CONTROL_RST = 16'h0000;
  localparam logic [15:0] DIAG_CHIP_CONTROL_RST = 16'h0000;
  localparam logic [15:0] SEC_CLOCK_CONTROL_RST = 16'h0000;
  localparam logic [7:0] PM_CAP_ID = 8'h01;
  localparam logic [7:0] PM_NEXT_PTR = 8'h00;
  localparam logic [15:0] PM_CAPS_DEFAULT = 16'h0602;

  // Timing in primary clocks
  localparam int PCLK_MHZ = 25;
  localparam int ACCESS_HOLDOFF_CLKS = 16;
  localparam int CHIP_CLEAR_MAX_CLKS = 20;
  localparam int CHIP_CLEAR_WAIT_CLKS = CHIP_CLEAR_MAX_CLKS / 2;
  localparam int SOFT_PULSE_CLKS = 4;

  // Power state field encoding
  typedef enum logic [1:0] {
    BRP_D0 = 2'h0,
    BRP_D1 = 2'h1,
    BRP_D2 = 2'h2,
    BRP_D3HOT = 2'h3
  } brp_pstate_t;

  // Secondary bus power state
  typedef enum logic [1:0] {
    BRP_B0 = 2'h0,
    BRP_B1 = 2'h1,
    BRP_B2 = 2'h2
  } brp_bstate_t;

  // Primary-side transaction offered to the bridge
  typedef struct packed {
    logic valid;
    logic is_config;
    logic type0;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } brp_req_t;

  // Answer to a transaction
  typedef struct packed {
    logic ack;
    logic ignored;
    logic [31:0] rdata;
  } brp_rsp_t;

endpackage : brp_pkg

/* rtl/brp_reset_power_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Support D0..D3cold; allow listed transitions only
// - Secondary bus B2 in D2/D3hot, B1 in D1
// - D0 to D3hot/D2 stops clocks if strapped
// - In D1 accept only Type 0 configuration
// - D3hot to D0: clocks on, internal reset only
// - Leaving D3cold needs full power-up reset
// - Power events never forwarded across the bridge
// - Primary reset floats buses except secondary data, which is driven low; resets all state
// - Primary reset edges may be asynchronous
// - No access during reset plus 16 clocks
// - Secondary reset follows primary reset release
// - Secondary-reset bit holds secondary reset asserted
// - Secondary reset floats control, drives data low
// - Secondary reset flushes all transaction buffers
// - Stay configurable during software secondary reset
// - Chip-reset bit resets all, sets secondary reset
// - Chip-reset bit self-clears within 20 clocks; clears 10 clocks after the secondary bit is cleared
// - Power capability at DCh, extensions at E0h
module brp_reset_power_ctrl
  import brp_pkg::*;
#(
  parameter int N_SEC_CLK = 5,
  parameter logic [15:0] PM_CAPS = PM_CAPS_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clock_stop_enable_strap,
  input wire logic clock_stop_enable_strap_alt,
  input wire brp_req_t req,
  output brp_rsp_t rsp,
  output logic [N_SEC_CLK-1:0] secondary_clock_outputs,
  output logic sec_reset_n,
  output logic chip_reset_n,
  output logic pri_bus_oe,
  output logic sec_ctrl_oe,
  output logic sec_data_drive_low,
  output logic buf_flush,
  output logic [1:0] power_state,
  output logic [1:0] sec_bus_state
);

  // Clock-disable bits live in a 16-bit register
  if (N_SEC_CLK < 1 || N_SEC_CLK > 16) begin : g_bad_nclk
    $error("N_SEC_CLK must be 1 to 16");
  end

  localparam logic [4:0] HOLDOFF_LOAD = 5'(ACCESS_HOLDOFF_CLKS);
  localparam logic [4:0] CLEAR_LOAD = 5'(CHIP_CLEAR_WAIT_CLKS);
  localparam logic [2:0] SOFT_LOAD = 3'(SOFT_PULSE_CLKS);

  //////////////////////////////////////////////////////////////////////////////

  // Byte-lane merge of a config write into a 16-bit half
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  // Only the listed transitions; rewriting the same state is harmless
  function automatic logic pstate_ok(input brp_pstate_t cur, input brp_pstate_t nxt);
    pstate_ok = (cur == nxt) ||
                (cur == BRP_D0) ||
                (cur == BRP_D3HOT && nxt == BRP_D0);
  endfunction : pstate_ok

  //////////////////////////////////////////////////////////////////////////////

  // Reset release synchroniser; assertion stays asynchronous
  logic [2:0] rst_pipe;
  logic rst_sync_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 3'h0;
    end else begin
      rst_pipe <= {rst_pipe[1:0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe[2];

  // Strap pins: three stages, accepted when the last two agree
  logic [2:0] strap_pipe;
  logic [2:0] strap_alt_pipe;
  logic strap_d3;
  logic strap_d2;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      strap_pipe <= 3'h0;
      strap_alt_pipe <= 3'h0;
    end else begin
      strap_pipe <= {strap_pipe[1:0], clock_stop_enable_strap};
      strap_alt_pipe <= {strap_alt_pipe[1:0], clock_stop_enable_strap_alt};
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      strap_d3 <= 1'b0;
      strap_d2 <= 1'b0;
    end else begin
      if (strap_pipe[2] == strap_pipe[1]) begin
        strap_d3 <= strap_pipe[2];
      end
      if (strap_alt_pipe[2] == strap_alt_pipe[1]) begin
        strap_d2 <= strap_alt_pipe[2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Access hold-off after primary reset release
  logic [4:0] holdoff_cnt;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      holdoff_cnt <= HOLDOFF_LOAD;
    end else if (holdoff_cnt != 5'h00) begin
      holdoff_cnt <= holdoff_cnt - 5'h01;
    end
  end

  // Register state
  logic [15:0] bridge_control;
  logic [15:0] diagnostic_chip_control;
  logic [15:0] secondary_clock_control;
  brp_pstate_t pstate;
  logic clk_stopped;

  // Internal soft reset: chip-reset bit or D3hot to D0
  logic [2:0] soft_cnt;
  logic soft_is_chip;
  logic soft_active;
  logic [4:0] clear_cnt;
  logic clear_pending;

  assign soft_active = (soft_cnt != 3'h0);

  // Request decode
  logic accessible;
  logic take;
  logic cfg_hit;
  logic cfg_wr;
  brp_pstate_t wr_pstate;
  logic sec_bit_cleared;
  logic chip_bit_written;
  logic d3_to_d0;

  // Inaccessible in reset, hold-off and the internal reset pulse
  assign accessible = rst_sync_b && (holdoff_cnt == 5'h00) && !soft_active;
  // In D1 only Type 0 configuration is taken
  assign take = req.valid && accessible &&
                (pstate != BRP_D1 || (req.is_config && req.type0));
  assign cfg_hit = take && req.is_config && req.type0;
  assign cfg_wr = cfg_hit && req.write;
  assign wr_pstate = brp_pstate_t'(req.wdata[1:0]);
  assign sec_bit_cleared = cfg_wr && req.addr == OFS_BRIDGE_CONTROL && req.be[2] &&
                           !req.wdata[16 + BC_SEC_RESET_BIT] &&
                           bridge_control[BC_SEC_RESET_BIT];
  assign chip_bit_written = cfg_wr && req.addr == OFS_DIAG_CHIP_CONTROL && req.be[0] &&
                            req.wdata[DIAG_CHIP_RESET_BIT] &&
                            !diagnostic_chip_control[DIAG_CHIP_RESET_BIT];
  assign d3_to_d0 = cfg_wr && req.addr == OFS_PM_DATA && req.be[0] &&
                    pstate == BRP_D3HOT && wr_pstate == BRP_D0;

  //////////////////////////////////////////////////////////////////////////////

  // Soft reset pulse; remembers whether the secondary bus joins it
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      soft_cnt <= 3'h0;
      soft_is_chip <= 1'b0;
    end else if (chip_bit_written) begin
      soft_cnt <= SOFT_LOAD;
      soft_is_chip <= 1'b1;
    end else if (d3_to_d0) begin
      soft_cnt <= SOFT_LOAD;
      soft_is_chip <= 1'b0;
    end else if (soft_active) begin
      soft_cnt <= soft_cnt - 3'h1;
    end
  end

  // Self-clear of the chip-reset bit once the secondary bit is cleared
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      clear_cnt <= 5'h00;
      clear_pending <= 1'b0;
    end else if (sec_bit_cleared && diagnostic_chip_control[DIAG_CHIP_RESET_BIT]) begin
      clear_cnt <= CLEAR_LOAD;
      clear_pending <= 1'b1;
    end else if (clear_pending) begin
      clear_cnt <= clear_cnt - 5'h01;
      clear_pending <= (clear_cnt != 5'h01);
    end
  end

  // Control registers; the soft pulse reloads defaults
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bridge_control <= BRIDGE_CONTROL_RST;
      diagnostic_chip_control <= DIAG_CHIP_CONTROL_RST;
      secondary_clock_control <= SEC_CLOCK_CONTROL_RST;
    end else if (soft_active) begin
      bridge_control <= BRIDGE_CONTROL_RST;
      diagnostic_chip_control <= DIAG_CHIP_CONTROL_RST;
      secondary_clock_control <= SEC_CLOCK_CONTROL_RST;
      // Chip reset leaves both bits set so the bus stays in reset
      bridge_control[BC_SEC_RESET_BIT] <= soft_is_chip;
      diagnostic_chip_control[DIAG_CHIP_RESET_BIT] <= soft_is_chip;
    end else begin
      if (cfg_wr && req.addr == OFS_BRIDGE_CONTROL) begin
        bridge_control <= merge16(bridge_control, req.wdata[31:16], req.be[3:2]);
      end
      if (cfg_wr && req.addr == OFS_DIAG_CHIP_CONTROL) begin
        diagnostic_chip_control <= merge16(diagnostic_chip_control, req.wdata[15:0],
                                           req.be[1:0]);
      end
      if (cfg_wr && req.addr == OFS_SEC_CLOCK_CONTROL) begin
        secondary_clock_control <= merge16(secondary_clock_control, req.wdata[15:0],
                                           req.be[1:0]);
      end
      // Expiry wins over a write of the same bit: hardware has the last word
      if (clear_pending && clear_cnt == 5'h01) begin
        diagnostic_chip_control[DIAG_CHIP_RESET_BIT] <= 1'b0;
      end
    end
  end

  // Power state and clock stop
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pstate <= BRP_D0;
      clk_stopped <= 1'b0;
    end else if (soft_active) begin
      pstate <= BRP_D0;
      clk_stopped <= 1'b0;
    end else if (cfg_wr && req.addr == OFS_PM_DATA && req.be[0] &&
                 pstate_ok(pstate, wr_pstate)) begin
      pstate <= wr_pstate;
      if (pstate == BRP_D0 && wr_pstate == BRP_D3HOT) begin
        clk_stopped <= strap_d3;
      end else if (pstate == BRP_D0 && wr_pstate == BRP_D2) begin
        clk_stopped <= strap_d2;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Read data mux
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (req.addr)
      OFS_CAP_PTR: rd_word = {24'h00_0000, OFS_PM_CAP};
      OFS_BRIDGE_CONTROL: rd_word = {bridge_control, 16'h0000};
      OFS_DIAG_CHIP_CONTROL: rd_word = {16'h0000, diagnostic_chip_control};
      OFS_SEC_CLOCK_CONTROL: rd_word = {16'h0000, secondary_clock_control};
      OFS_PM_CAP: rd_word = {PM_CAPS, PM_NEXT_PTR, PM_CAP_ID};
      OFS_PM_DATA: begin
        rd_word = {30'h0000_0000, pstate};
        rd_word[16 + PPB_CLK_STOP_BIT] = strap_d3;
        rd_word[16 + PPB_B2_B3_BIT] = 1'b1;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Answer one cycle after the request; refused requests flag ignored
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rsp <= '0;
    end else begin
      rsp.ack <= take;
      rsp.ignored <= req.valid && !take;
      rsp.rdata <= (cfg_hit && !req.write) ? rd_word : 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Secondary reset: asynchronous on primary reset, released after sync
  logic sec_rst_active;

  assign sec_rst_active = bridge_control[BC_SEC_RESET_BIT] ||
                          (soft_active && soft_is_chip);

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sec_reset_n <= 1'b0;
    end else begin
      sec_reset_n <= !sec_rst_active;
    end
  end

  // Bus drive controls; D3hot exit does not touch the secondary bus
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pri_bus_oe <= 1'b0;
      sec_ctrl_oe <= 1'b0;
      sec_data_drive_low <= 1'b1;
      buf_flush <= 1'b1;
      chip_reset_n <= 1'b0;
    end else begin
      pri_bus_oe <= !(soft_active && soft_is_chip);
      sec_ctrl_oe <= !sec_rst_active && !(soft_active && soft_is_chip);
      sec_data_drive_low <= sec_rst_active;
      buf_flush <= sec_rst_active || soft_active;
      chip_reset_n <= !soft_active;
    end
  end

  // Power state and secondary bus state
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      power_state <= BRP_D0;
      sec_bus_state <= BRP_B0;
    end else begin
      power_state <= pstate;
      unique case (pstate)
        BRP_D1: sec_bus_state <= BRP_B1;
        BRP_D2, BRP_D3HOT: sec_bus_state <= BRP_B2;
        default: sec_bus_state <= BRP_B0;
      endcase
    end
  end

  // Secondary clocks at half rate; stopped clocks sit low
  logic clk_phase;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_phase <= 1'b0;
    end else begin
      clk_phase <= !clk_phase;
    end
  end

  // Gating from a flop keeps every emitted pulse a full period wide
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      secondary_clock_outputs <= '0;
    end else begin
      for (int i = 0; i < N_SEC_CLK; i++) begin
        secondary_clock_outputs[i] <= !clk_phase && !clk_stopped &&
                                      !secondary_clock_control[i];
      end
    end
  end

  // Wake signalling from downstream has no path through this block

endmodule : brp_reset_power_ctrl

`default_nettype wire

/* sim/brp_reset_power_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on the reset and power-state control block
module brp_reset_power_ctrl_asserts
  import brp_pkg::*;
#(
  parameter int N_SEC_CLK = 5
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clock_stop_enable_strap,
  input wire logic clock_stop_enable_strap_alt,
  input wire brp_req_t req,
  input wire brp_rsp_t rsp,
  input wire logic [N_SEC_CLK-1:0] secondary_clock_outputs,
  input wire logic sec_reset_n,
  input wire logic chip_reset_n,
  input wire logic pri_bus_oe,
  input wire logic sec_ctrl_oe,
  input wire logic sec_data_drive_low,
  input wire logic buf_flush,
  input wire logic [1:0] power_state,
  input wire logic [1:0] sec_bus_state
);
  logic [4:0] since_rel;
  // Cycles since release; saturates so it never wraps back into the hold-off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      since_rel <= 5'h00;
    end else if (since_rel != 5'h1F) begin
      since_rel <= since_rel + 5'h01;
    end
  end
  brp_req_t req_q;
  logic taken_wr;
  logic chip_cause;
  assign taken_wr = rsp.ack && req_q.is_config && req_q.type0 && req_q.write;
  // Cause of the last internal pulse; a wake pulse looks the same at chip_reset_n
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= '0;
      chip_cause <= 1'b0;
    end else begin
      req_q <= req;
      if (taken_wr && req_q.addr == OFS_DIAG_CHIP_CONTROL && req_q.be[0] &&
          req_q.wdata[DIAG_CHIP_RESET_BIT]) begin
        chip_cause <= 1'b1;
      end else if (taken_wr && req_q.addr == OFS_PM_DATA) begin
        chip_cause <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  property p_hold_off;
    since_rel <= 5'h12 |-> !rsp.ack;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("access taken during hold-off");
  property p_bus_b1;
    (power_state == BRP_D1) [*2] |-> sec_bus_state == BRP_B1;
  endproperty
  a_bus_b1: assert property (p_bus_b1) else $error("secondary bus not in B1");
  property p_bus_b2;
    (power_state == BRP_D2 || power_state == BRP_D3HOT) [*2] |-> sec_bus_state == BRP_B2;
  endproperty
  a_bus_b2: assert property (p_bus_b2) else $error("secondary bus not in B2");
  property p_clk_stop;
    ((power_state == BRP_D3HOT && clock_stop_enable_strap) ||
     (power_state == BRP_D2 && clock_stop_enable_strap_alt)) [*6]
      |-> secondary_clock_outputs == '0;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("secondary clocks running");
  property p_d1_filter;
    power_state == BRP_D1 && req.valid && !(req.is_config && req.type0)
      |=> rsp.ignored && !rsp.ack;
  endproperty
  a_d1_filter: assert property (p_d1_filter) else $error("D1 took a foreign cycle");
  property p_sec_set;
    rsp.ack && $past(req.is_config && req.type0 && req.write && req.be[2]) &&
      $past(req.addr) == OFS_BRIDGE_CONTROL && $past(req.wdata[16 + BC_SEC_RESET_BIT])
      |=> !sec_reset_n;
  endproperty
  a_sec_set: assert property (p_sec_set) else $error("secondary reset not asserted");
  property p_sec_quiet;
    !sec_reset_n |-> !sec_ctrl_oe && sec_data_drive_low && buf_flush;
  endproperty
  a_sec_quiet: assert property (p_sec_quiet) else $error("secondary bus not quiet");
  property p_chip_float;
    !chip_reset_n && chip_cause |-> !pri_bus_oe;
  endproperty
  a_chip_float: assert property (p_chip_float) else $error("primary driven in chip reset");
  property p_wake_quiet;
    power_state == BRP_D0 && $past(power_state) == BRP_D3HOT && !chip_cause
      |-> sec_reset_n [*3];
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("secondary reset on wake");
  // Main scenarios reached
  c_sec_access: cover property (rsp.ack && !sec_reset_n);
  c_d1_refuse: cover property (power_state == BRP_D1 && rsp.ignored);
  c_chip_pulse: cover property ($fell(chip_reset_n));
endmodule : brp_reset_power_ctrl_asserts
bind brp_reset_power_ctrl brp_reset_power_ctrl_asserts #(.N_SEC_CLK(N_SEC_CLK)) i_chk (
  .clk(clk), .rst_b(rst_b), .clock_stop_enable_strap(clock_stop_enable_strap),
  .clock_stop_enable_strap_alt(clock_stop_enable_strap_alt), .req(req), .rsp(rsp),
  .secondary_clock_outputs(secondary_clock_outputs), .sec_reset_n(sec_reset_n),
  .chip_reset_n(chip_reset_n), .pri_bus_oe(pri_bus_oe), .sec_ctrl_oe(sec_ctrl_oe),
  .sec_data_drive_low(sec_data_drive_low), .buf_flush(buf_flush),
  .power_state(power_state), .sec_bus_state(sec_bus_state));
`default_nettype wire

/* sim/brp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Upstream host: one cycle at a time, never two in flight
module brp_host_model
  import brp_pkg::*;
(
  input wire logic clk,
  output var brp_req_t req,
  input wire brp_rsp_t rsp
);
  // Idle at time zero
  initial begin
    req = '0;
  end
  // Drive after a falling edge, taken at the rising edge, answer read while it stands
  task automatic xfer(input logic cfg, input logic t0, input logic wr, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] d, output brp_rsp_t got);
    @(negedge clk);
    req = '{valid: 1'b1, is_config: cfg, type0: t0, write: wr, addr: a, be: be, wdata: d};
    @(negedge clk);
    got = rsp; // The answer stands for one cycle only
    req = {1'b0, ~req[$bits(brp_req_t)-2:0]}; // Released fields never hold the stale request
  endtask : xfer
endmodule : brp_host_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb import brp_pkg::*;;
  logic clk;
  logic rst_b;
  logic strap;
  logic strap_alt;
  brp_req_t req;
  brp_rsp_t rsp;
  brp_rsp_t got;
  logic [4:0] sclk;
  logic [4:0] s0;
  logic sec_reset_n, chip_reset_n, pri_bus_oe, sec_ctrl_oe, sec_data_drive_low, buf_flush;
  logic [1:0] power_state;
  logic [1:0] sec_bus_state;
  logic [31:0] seed;
  int err_total;
  int total_checks;
  ////////////////////////////////////////////////////////////////////////////////
  brp_reset_power_ctrl #(.N_SEC_CLK(5)) i_dut (
    .clk(clk), .rst_b(rst_b), .clock_stop_enable_strap(strap),
    .clock_stop_enable_strap_alt(strap_alt), .req(req), .rsp(rsp),
    .secondary_clock_outputs(sclk), .sec_reset_n(sec_reset_n), .chip_reset_n(chip_reset_n),
    .pri_bus_oe(pri_bus_oe), .sec_ctrl_oe(sec_ctrl_oe),
    .sec_data_drive_low(sec_data_drive_low), .buf_flush(buf_flush),
    .power_state(power_state), .sec_bus_state(sec_bus_state));
  brp_host_model i_host (.clk(clk), .req(req), .rsp(rsp));
  // 25 MHz primary clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Power data dword: strap readback in bit 23, bit 22 fixed high, state in 1:0
  function automatic logic [31:0] pm_word(input logic [1:0] ps);
    return {8'h00, strap, 1'b1, 6'h00, 14'h0000, ps};
  endfunction : pm_word
  task automatic end_sim();
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    i_host.xfer(1'b1, 1'b1, wr, a, be, d, got);
  endtask : cfg
  // Reset held 12 cycles; outputs checked while it is still held
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (12) @(negedge clk);
    chk("reset outs", 32'h3, {26'h0, sec_reset_n, chip_reset_n, pri_bus_oe, sec_ctrl_oe,
        sec_data_drive_low, buf_flush});
    chk("reset clocks", 32'h0, {27'h0, sclk});
    rst_b = 1'b1;
    repeat (20) @(negedge clk);
  endtask : do_reset
  // Caps a hung run
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    total_checks = 0;
    seed = 32'h3D2A;
    strap = 1'b1;
    strap_alt = 1'b1;
    rst_b = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    // Past the release synchroniser, inside the hold-off; answers are silent in reset
    repeat (4) @(negedge clk);
    cfg(1'b0, OFS_PM_CAP, 4'hF, 32'h0);
    chk("early access", 32'h1, {31'h0, got.ignored});
    do_reset();
    cfg(1'b0, OFS_PM_CAP, 4'hF, 32'h0);
    chk("pm cap", {PM_CAPS_DEFAULT, PM_NEXT_PTR, PM_CAP_ID}, got.rdata);
    cfg(1'b0, OFS_CAP_PTR, 4'hF, 32'h0);
    chk("cap ptr", {24'h0, OFS_PM_CAP}, got.rdata);
    cfg(1'b0, OFS_PM_DATA, 4'hF, 32'h0);
    chk("pm data", pm_word(BRP_D0), got.rdata);
    cfg(1'b0, OFS_BRIDGE_CONTROL, 4'hF, 32'h0);
    chk("bridge ctl", {BRIDGE_CONTROL_RST, 16'h0}, got.rdata);
    cfg(1'b0, OFS_DIAG_CHIP_CONTROL, 4'hF, 32'h0);
    chk("diag ctl", {16'h0, DIAG_CHIP_CONTROL_RST}, got.rdata);
    // Random unmapped reads and random clock disables
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      cfg(1'b0, {2'b10, seed[5:2], 2'b00}, 4'hF, 32'h0);
      chk("unmapped", 32'h0, got.rdata);
      cfg(1'b1, OFS_SEC_CLOCK_CONTROL, 4'h3, {27'h0, seed[20:16] | 5'h01});
      repeat (3) @(negedge clk);
      chk("clk disable", 32'h0, {27'h0, sclk & (seed[20:16] | 5'h01)});
    end
    // Software secondary reset, bridge stays configurable
    cfg(1'b1, OFS_BRIDGE_CONTROL, 4'hC, 32'h1 << (16 + BC_SEC_RESET_BIT));
    @(negedge clk);
    chk("sec reset", 32'h0, {31'h0, sec_reset_n});
    chk("sec quiet", 32'h3, {29'h0, sec_ctrl_oe, sec_data_drive_low, buf_flush});
    cfg(1'b0, OFS_PM_CAP, 4'hF, 32'h0);
    chk("access in sec reset", 32'h1, {31'h0, got.ack});
    cfg(1'b1, OFS_BRIDGE_CONTROL, 4'hC, 32'h0);
    @(negedge clk);
    chk("sec release", 32'h1, {31'h0, sec_reset_n});
    // Chip reset through the diagnostic register
    cfg(1'b1, OFS_DIAG_CHIP_CONTROL, 4'h3, 32'h1 << DIAG_CHIP_RESET_BIT);
    @(negedge clk);
    chk("chip pulse", 32'h0, {29'h0, chip_reset_n, pri_bus_oe, sec_reset_n});
    repeat (6) @(negedge clk);
    cfg(1'b0, OFS_BRIDGE_CONTROL, 4'hF, 32'h0);
    chk("sec bit auto", 32'h1 << (16 + BC_SEC_RESET_BIT), got.rdata);
    cfg(1'b0, OFS_DIAG_CHIP_CONTROL, 4'hF, 32'h0);
    chk("chip bit", 32'h1 << DIAG_CHIP_RESET_BIT, got.rdata);
    cfg(1'b1, OFS_BRIDGE_CONTROL, 4'hC, 32'h0);
    // Read is taken 20 clocks after the clearing write
    repeat (18) @(negedge clk);
    cfg(1'b0, OFS_DIAG_CHIP_CONTROL, 4'hF, 32'h0);
    chk("chip bit clear", 32'h0, got.rdata);
    // D3hot and back: clocks stop, then wake without secondary reset
    cfg(1'b1, OFS_SEC_CLOCK_CONTROL, 4'h3, 32'h1);
    cfg(1'b1, OFS_PM_DATA, 4'h1, {30'h0, BRP_D3HOT});
    repeat (8) @(negedge clk);
    chk("d3hot", {27'h0, BRP_D3HOT, BRP_B2, 1'b0}, {27'h0, power_state, sec_bus_state, |sclk});
    cfg(1'b1, OFS_PM_DATA, 4'h1, {30'h0, BRP_D0});
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      chk("wake sec reset", 32'h1, {31'h0, sec_reset_n});
    end
    s0 = sclk;
    @(negedge clk);
    chk("clocks run", {27'h0, ~s0}, {27'h0, sclk});
    cfg(1'b0, OFS_SEC_CLOCK_CONTROL, 4'hF, 32'h0);
    chk("wake defaults", {16'h0, SEC_CLOCK_CONTROL_RST}, got.rdata);
    // D1: only type 0 configuration answered, no way back but reset
    cfg(1'b1, OFS_PM_DATA, 4'h1, {30'h0, BRP_D1});
    repeat (2) @(negedge clk);
    chk("d1", {28'h0, BRP_D1, BRP_B1}, {28'h0, power_state, sec_bus_state});
    i_host.xfer(1'b0, 1'b1, 1'b0, OFS_PM_CAP, 4'hF, 32'h0, got);
    chk("d1 memory", 32'h1, {31'h0, got.ignored});
    i_host.xfer(1'b1, 1'b0, 1'b0, OFS_PM_CAP, 4'hF, 32'h0, got);
    chk("d1 type1", 32'h1, {31'h0, got.ignored});
    cfg(1'b0, OFS_PM_DATA, 4'hF, 32'h0);
    chk("d1 type0", pm_word(BRP_D1), got.rdata);
    cfg(1'b1, OFS_PM_DATA, 4'h1, {30'h0, BRP_D0});
    repeat (2) @(negedge clk);
    chk("d1 stays", {30'h0, BRP_D1}, {30'h0, power_state});
    do_reset();
    // D2 with the alternate strap
    cfg(1'b1, OFS_PM_DATA, 4'h1, {30'h0, BRP_D2});
    repeat (8) @(negedge clk);
    chk("d2", {27'h0, BRP_D2, BRP_B2, 1'b0}, {27'h0, power_state, sec_bus_state, |sclk});
    end_sim();
  end
endmodule : tb
`default_nettype wire
